// File: rtl/aalf_core.sv
`timescale 1ns/1ps
`include "aalf_defs.svh"
// Function
// - add-literal: accumulator plus literal into accumulator, carry, half-carry, zero updated
// - and-literal: accumulator and literal into accumulator, only zero updated
// - add-file: accumulator plus addressed file register, carry, half-carry, zero updated
// - and-file: accumulator and addressed file register, only zero updated
// - destination bit clear writes accumulator, set writes file register back
module aalf_core (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  instr_valid,
  input  wire aalf_pkg::aalf_instr_t instr,
  output aalf_pkg::aalf_byte_t       acc,
  output logic                       carry_flag,
  output logic                       half_carry_flag,
  output logic                       zero_flag,
  output logic                       file_wr,
  output aalf_pkg::aalf_addr_t       file_wr_addr,
  output aalf_pkg::aalf_byte_t       file_wr_data,
  output logic                       done
);
  // ****************************************
  // decode
  // ****************************************
  // file operand is read in the cycle after the instruction is taken, so the
  // instruction is held one cycle; throughput is one instruction per cycle pair
  aalf_pkg::aalf_instr_t ir_q;
  logic                  ex_q;
  aalf_pkg::aalf_byte_t  acc_q;
  logic                  c_q, hc_q, z_q;
  logic                  fw_q;
  aalf_pkg::aalf_addr_t  fa_q;
  aalf_pkg::aalf_byte_t  fd_q;
  logic                  done_q;
  aalf_pkg::aalf_byte_t  file_rd;

  wire is_addlit  = (ir_q & `AALF_OP_ADDLIT_MASK) == `AALF_OP_ADDLIT_VAL;
  wire is_andlit  = (ir_q & `AALF_OP_ANDLIT_MASK) == `AALF_OP_ANDLIT_VAL;
  wire is_addfile = (ir_q & `AALF_OP_FILE_MASK) == `AALF_OP_ADDFILE_VAL;
  wire is_andfile = (ir_q & `AALF_OP_FILE_MASK) == `AALF_OP_ANDFILE_VAL;
  wire is_add     = is_addlit | is_addfile;
  wire is_file    = is_addfile | is_andfile;
  wire known      = is_add | is_andlit | is_andfile;
  wire dest_file  = is_file & ir_q[`AALF_DEST_BIT];
  wire aalf_pkg::aalf_addr_t addr = ir_q[`AALF_ADDR_MSB:0];
  wire aalf_pkg::aalf_addr_t rd_addr = instr[`AALF_ADDR_MSB:0];
  wire aalf_pkg::aalf_byte_t operand = is_file ? file_rd : ir_q[`AALF_LIT_MSB:0];

  // ****************************************
  // arithmetic
  // ****************************************
  wire [4:0] lo_sum = {1'b0, acc_q[`AALF_HALF_MSB:0]} + {1'b0, operand[`AALF_HALF_MSB:0]};
  wire [8:0] sum    = {1'b0, acc_q} + {1'b0, operand};
  wire aalf_pkg::aalf_byte_t result = is_add ? sum[7:0] : (acc_q & operand);
  wire res_zero = (result == `AALF_ZERO_BYTE);
  wire fire     = ex_q & known;

  aalf_file_mem u_mem (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (fw_q),
    .wr_addr (fa_q),
    .wr_data (fd_q),
    .rd_addr (rd_addr),
    .rd_data (file_rd)
  );

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_q <= '0;
      ex_q <= 1'b0;
    end else begin
      ir_q <= instr;
      // slot alternates so the registered file read always lines up with execution
      ex_q <= instr_valid & ~ex_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q  <= `AALF_ACC_RESET;
      c_q    <= `AALF_FLAG_RESET;
      hc_q   <= `AALF_FLAG_RESET;
      z_q    <= `AALF_FLAG_RESET;
      fw_q   <= 1'b0;
      fa_q   <= '0;
      fd_q   <= `AALF_FILE_RESET;
      done_q <= 1'b0;
    end else begin
      done_q <= fire;
      fw_q   <= fire & dest_file;
      fa_q   <= addr;
      fd_q   <= result;
      if (fire && !dest_file) begin
        acc_q <= result;
      end
      if (fire) begin
        z_q <= res_zero;
      end
      if (fire && is_add) begin
        c_q  <= sum[`AALF_CARRY_BIT];
        hc_q <= lo_sum[`AALF_HALF_CARRY];
      end
    end
  end

  assign acc             = acc_q;
  assign carry_flag      = c_q;
  assign half_carry_flag = hc_q;
  assign zero_flag       = z_q;
  assign file_wr         = fw_q;
  assign file_wr_addr    = fa_q;
  assign file_wr_data    = fd_q;
  assign done            = done_q;

  // ****************************************
  // checks
  // ****************************************
  property p_addlit;
    @(posedge clk) disable iff (rst)
    (ex_q && is_addlit) |=> (acc == $past(sum[7:0])) && (carry_flag == $past(sum[`AALF_CARRY_BIT]));
  endproperty
  a_addlit: assert property (p_addlit) else $error("add literal result wrong");

  property p_andlit;
    @(posedge clk) disable iff (rst)
    (ex_q && is_andlit) |=> (acc == ($past(acc_q) & $past(ir_q[`AALF_LIT_MSB:0]))) && $stable(carry_flag);
  endproperty
  a_andlit: assert property (p_andlit) else $error("and literal result wrong");

  property p_addfile;
    @(posedge clk) disable iff (rst)
    (ex_q && is_addfile) |=> (half_carry_flag == $past(lo_sum[`AALF_HALF_CARRY]));
  endproperty
  a_addfile: assert property (p_addfile) else $error("add file half carry wrong");

  property p_andfile;
    @(posedge clk) disable iff (rst)
    (ex_q && is_andfile) |=> $stable(carry_flag) && $stable(half_carry_flag);
  endproperty
  a_andfile: assert property (p_andfile) else $error("and file touched carry");

  property p_dest_file;
    @(posedge clk) disable iff (rst)
    (ex_q && is_file && ir_q[`AALF_DEST_BIT]) |=> file_wr && $stable(acc) && (file_wr_addr == $past(addr));
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_dest_acc;
    @(posedge clk) disable iff (rst)
    (ex_q && is_file && !ir_q[`AALF_DEST_BIT]) |=> !file_wr && (acc == $past(result));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrong");

  property p_zero;
    @(posedge clk) disable iff (rst)
    fire |=> done && (zero_flag == (file_wr ? (file_wr_data == `AALF_ZERO_BYTE) : (acc == `AALF_ZERO_BYTE)));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_one_cycle;
    @(posedge clk) disable iff (rst)
    (instr_valid && !ex_q) |=> ex_q ##1 !ex_q;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("execution slot wrong");

  // literal nibble sum straight from the word, not through the operand mux
  wire [4:0] lit_lo = {1'b0, acc_q[`AALF_HALF_MSB:0]} + {1'b0, ir_q[`AALF_HALF_MSB:0]};
  // file results land on whichever output the destination bit picked
  wire aalf_pkg::aalf_byte_t dest_val = file_wr ? file_wr_data : acc;

  property p_addlit_flags;
    @(posedge clk) disable iff (rst)
    (ex_q && is_addlit) |=> (half_carry_flag == $past(lit_lo[`AALF_HALF_CARRY]))
                            && (zero_flag == (acc == `AALF_ZERO_BYTE));
  endproperty
  a_addlit_flags: assert property (p_addlit_flags) else $error("add literal flags wrong");

  property p_andlit_zero;
    @(posedge clk) disable iff (rst)
    (ex_q && is_andlit) |=> (zero_flag == (acc == `AALF_ZERO_BYTE)) && $stable(half_carry_flag);
  endproperty
  a_andlit_zero: assert property (p_andlit_zero) else $error("and literal zero flag wrong");

  property p_addfile_sum;
    @(posedge clk) disable iff (rst)
    (ex_q && is_addfile) |=> ({carry_flag, dest_val} == ({1'b0, $past(acc_q)} + {1'b0, $past(file_rd)}));
  endproperty
  a_addfile_sum: assert property (p_addfile_sum) else $error("add file sum or carry wrong");

  property p_andfile_val;
    @(posedge clk) disable iff (rst)
    (ex_q && is_andfile) |=> (dest_val == ($past(acc_q) & $past(file_rd)))
                             && (zero_flag == (dest_val == `AALF_ZERO_BYTE));
  endproperty
  a_andfile_val: assert property (p_andfile_val) else $error("and file result wrong");

  // unknown words still use the slot but must leave done, file_wr, acc and the flags alone
  property p_idle_hold;
    @(posedge clk) disable iff (rst)
    !fire |=> !done && !file_wr && $stable(acc) && $stable(carry_flag) && $stable(half_carry_flag)
              && $stable(zero_flag);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state changed without an instruction");

  property p_done_pulse;
    @(posedge clk) disable iff (rst)
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");

  // ****************************************
  // cover
  // ****************************************
  c_addlit_carry:  cover property (@(posedge clk) disable iff (rst) ex_q && is_addlit && sum[`AALF_CARRY_BIT]);
  c_file_back:     cover property (@(posedge clk) disable iff (rst) ex_q && dest_file);
  c_andfile_acc:   cover property (@(posedge clk) disable iff (rst) ex_q && is_andfile && !dest_file);
  c_addfile_carry: cover property (@(posedge clk) disable iff (rst) ex_q && is_addfile && sum[`AALF_CARRY_BIT]);
  c_andlit_zero:   cover property (@(posedge clk) disable iff (rst) ex_q && is_andlit && res_zero);
endmodule

// File: rtl/aalf_defs.svh
`ifndef AALF_DEFS_SVH
`define AALF_DEFS_SVH
`define AALF_OP_ADDLIT_MASK 14'h3e00
`define AALF_OP_ADDLIT_VAL  14'h3e00
`define AALF_OP_ANDLIT_MASK 14'h3f00
`define AALF_OP_ANDLIT_VAL  14'h3900
`define AALF_OP_FILE_MASK   14'h3f00
`define AALF_OP_ADDFILE_VAL 14'h0700
`define AALF_OP_ANDFILE_VAL 14'h0500
`define AALF_DEST_BIT       7
`define AALF_ADDR_MSB       6
`define AALF_LIT_MSB        7
`define AALF_HALF_MSB       3
`define AALF_HALF_CARRY     4
`define AALF_CARRY_BIT      8
`define AALF_ZERO_BYTE      8'h00
`define AALF_ACC_RESET      8'h00
`define AALF_FLAG_RESET     1'b0
`define AALF_FILE_RESET     8'h00
`define AALF_FILE_DEPTH     128
`endif

// File: rtl/aalf_file_mem.sv
`timescale 1ns/1ps
`include "aalf_defs.svh"
module aalf_file_mem (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wr_en,
  input  wire aalf_pkg::aalf_addr_t  wr_addr,
  input  wire aalf_pkg::aalf_byte_t  wr_data,
  input  wire aalf_pkg::aalf_addr_t  rd_addr,
  output aalf_pkg::aalf_byte_t       rd_data
);
  aalf_pkg::aalf_byte_t mem [`AALF_FILE_DEPTH];
  aalf_pkg::aalf_byte_t rd_q;
  assign rd_data = rd_q;
  // write-first bypass so back-to-back use of one register sees fresh data
  wire aalf_pkg::aalf_byte_t rd_d = (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q <= `AALF_FILE_RESET;
    end else begin
      rd_q <= rd_d;
    end
  end
endmodule

// File: rtl/aalf_pkg.sv
package aalf_pkg;
  typedef logic [13:0] aalf_instr_t;
  typedef logic [7:0]  aalf_byte_t;
  typedef logic [6:0]  aalf_addr_t;
  typedef enum logic [1:0] {
    AALF_ST_IDLE  = 2'b00,
    AALF_ST_FETCH = 2'b01,
    AALF_ST_EXEC  = 2'b10
  } aalf_state_e;
endpackage

// File: sim/aalf_fetch_model.sv
`timescale 1ns/1ps
// ****************************************
// fetch stage: each word stands two edges
// ****************************************
module aalf_fetch_model (
  input  wire logic             clk,
  input  wire logic             rst,
  output logic                  instr_valid,
  output aalf_pkg::aalf_instr_t instr
);
  aalf_pkg::aalf_instr_t q[$];
  logic                  hold_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_valid <= 1'b0;
      instr       <= 14'h0000;
      hold_q      <= 1'b0;
    end else if (instr_valid && !hold_q) begin
      hold_q <= 1'b1;
    end else if (q.size() > 0) begin
      instr       <= q.pop_front();
      instr_valid <= 1'b1;
      hold_q      <= 1'b0;
    end else begin
      // idle word keeps moving so a stale value cannot pass
      instr_valid <= 1'b0;
      instr       <= ~instr;
      hold_q      <= 1'b0;
    end
  end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  typedef struct {
    aalf_pkg::aalf_byte_t acc;
    logic                 c, hc, z, fw;
    aalf_pkg::aalf_addr_t adr;
    aalf_pkg::aalf_byte_t dat;
  } aalf_exp_s;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  instr_valid, carry_flag, half_carry_flag, zero_flag, file_wr, done;
  aalf_pkg::aalf_instr_t instr;
  aalf_pkg::aalf_byte_t  acc, file_wr_data;
  aalf_pkg::aalf_addr_t  file_wr_addr;
  int                    err_count = 0;
  int                    checked = 0;
  int                    cycles = 0;
  aalf_exp_s             eq[$];
  aalf_exp_s             r, e;
  aalf_pkg::aalf_byte_t  mem [128];
  logic [5:0]            ops [6] = '{6'h3e, 6'h3f, 6'h39, 6'h07, 6'h05, 6'h0a};
  aalf_pkg::aalf_instr_t corner [13] = '{14'h3e10, 14'h3e15, 14'h3fdb, 14'h3e0f, 14'h0785, 14'h0705, 14'h3900,
    14'h3ea3, 14'h395f, 14'h0000, 14'h3a00, 14'h3fff, 14'h3e01};
  always #12.5 clk = ~clk;
  aalf_fetch_model fm (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr));
  aalf_core uut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .acc(acc),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .file_wr(file_wr), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .done(done));
  task automatic final_report();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // reference model; unrecognised words expect nothing
  task automatic step(input aalf_pkg::aalf_instr_t w);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] opd, res;
    logic       isadd, isand;
    fm.q.push_back(w);
    isadd = (w[13:9] == 5'h1f) || (w[13:8] == 6'h07);
    isand = (w[13:8] == 6'h39) || (w[13:8] == 6'h05);
    if (!isadd && !isand) return;
    opd = w[13] ? w[7:0] : mem[w[6:0]];
    s = {1'b0, r.acc} + {1'b0, opd};
    h = {1'b0, r.acc[3:0]} + {1'b0, opd[3:0]};
    res = isadd ? s[7:0] : (r.acc & opd);
    if (isadd) begin
      r.c = s[8];
      r.hc = h[4];
    end
    r.z = (res == 8'h00);
    r.fw = !w[13] && w[7];
    r.adr = w[6:0];
    r.dat = res;
    if (r.fw) mem[w[6:0]] = res;
    else r.acc = res;
    eq.push_back(r);
  endtask
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (eq.size() == 0) `CHK(done, 1'b0)
      else begin
        e = eq.pop_front();
        `CHK(acc, e.acc)
        `CHK({carry_flag, half_carry_flag}, {e.c, e.hc})
        `CHK(zero_flag, e.z)
        `CHK(file_wr, e.fw)
        if (e.fw) `CHK({file_wr_addr, file_wr_data}, {e.adr, e.dat})
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(70));
    r = '{default: '0};
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK({acc, carry_flag, half_carry_flag, zero_flag, file_wr, done}, 13'h0000)
    // acc zero makes and-file write zero over unknown file contents
    step(14'h3900);
    for (int a = 0; a < 128; a++) step(14'h0580 | 14'(a));
    foreach (corner[i]) step(corner[i]);
    repeat (300) step({ops[$urandom % 6], 8'($urandom)});
    for (int i = 0; i < 3000 && (fm.q.size() > 0 || eq.size() > 0); i++) @(posedge clk);
    repeat (4) @(posedge clk);
    `CHK(eq.size(), 0)
    final_report();
  end
endmodule
